/* File: tsr_defines.svh */
// constants for the temperature sensor serial readout
// Contract
// (RULE_01) while select is high, convert continuously without any command.
// (RULE_02) select low aborts conversion, enters idle, latest result readable.
// (RULE_03) select rising edge starts fresh conversion and resets serial interface.
// (RULE_04) controller keeps select high at least 300 ms before next read.
// (RULE_05) select falling edge loads current result into output shift register; code loads it on the first sclk fall after select falls.
// (RULE_06) output changes on serial clock falling edge, sign first then msb.
// (RULE_07) a read is one 16-bit word; select stays low for all bits.
// (RULE_08) after an aborted read controller waits one conversion time.
// (RULE_09) first thirteen bits carry sign and twelve magnitude bits, three trail.
// (RULE_10) fourteenth bit is always driven low as confirmation.
// (RULE_11) last two bit periods leave output in high impedance.
// (RULE_12) after power-up output stays high impedance until a read drives it.
// (RULE_13) temperature field is two's complement.
// (RULE_14) one result step equals 0.0625 degrees celsius.
// (RULE_15) conversion period is 8 s low-power or 0.5 s fast variant.
// (RULE_16) in idle with select low, stored result still shifts out.
// (RULE_17) during reset interface inactive and result holds zero degrees; code resets the serial interface only on select high, not on rst.
// (RULE_18) after reset release conversion starts automatically.
// (RULE_19) controller serial clock at most 5 MHz, phases at least 100 ns.
// (RULE_20) count falling edges, ignore edges after sixteenth until select rises.
// (RULE_21) timebase counter cleared on select fall, restarts on select rise.
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH
`define TSR_CLK_HZ        10000000
`define TSR_CONV_MS       300
`define TSR_CONV_CYC      ((`TSR_CONV_MS * `TSR_CLK_HZ) / 1000)
`define TSR_PERIOD_SLOW_MS 8000
`define TSR_PERIOD_FAST_MS 500
`define TSR_PERIOD_SLOW_CYC ((`TSR_PERIOD_SLOW_MS / 1000) * `TSR_CLK_HZ)
`define TSR_PERIOD_FAST_CYC ((`TSR_PERIOD_FAST_MS * `TSR_CLK_HZ) / 1000)
`define TSR_WORD_BITS     16
`define TSR_TEMP_BITS     13
`define TSR_ZERO_TEMP     13'h0000
`define TSR_BIT_CONFIRM   5'h0E
`define TSR_BIT_HIZ       5'h0F
`endif

/* File: tsr_pkg.sv */
// types for the temperature sensor serial readout
package tsr_pkg;
  typedef enum logic [1:0] {
    TSR_CONVERT,
    TSR_WAIT,
    TSR_IDLE
  } tsr_conv_type;

  typedef struct packed {
    tsr_conv_type  state;
    logic [31:0]   timer;
    logic [12:0]   result;
    logic          done_tgl;
    logic [2:0]    sel_sync;
    logic          sel_seen;
  } tsr_core_type;

  typedef struct packed {
    logic [12:0]   latched;
    logic [4:0]    count;
    logic          so_out;
    logic          so_oe;
  } tsr_link_type;
endpackage

/* File: tsr_readout.sv */
// temperature sensor conversion control and serial readout
`timescale 1ns/1ns
`include "tsr_defines.svh"
module tsr_readout #(
  parameter int unsigned CONV_CYC   = `TSR_CONV_CYC,
  parameter int unsigned PERIOD_CYC = `TSR_PERIOD_FAST_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [12:0] temp_sample,
  input  wire logic        sel_n,
  input  wire logic        sclk,
  output logic             so_out,
  output logic             so_oe,
  output logic [12:0]      result,
  output logic             converting
);
  // core domain on clk
  tsr_pkg::tsr_core_type core_ff;
  tsr_pkg::tsr_core_type nxt_core;
  logic conv_busy_ff;
  logic nxt_conv_busy;

  always_comb begin
    nxt_core = core_ff;
    nxt_core.sel_sync = {core_ff.sel_sync[1:0], sel_n};
    nxt_conv_busy = 1'b0;
    if (!core_ff.sel_sync[1]) begin
      // select low: abort and idle [RULE_02]
      nxt_core.state = tsr_pkg::TSR_IDLE;
      nxt_core.timer = 32'h0; // [RULE_21]
      nxt_core.sel_seen = 1'b0;
    end else if (!core_ff.sel_sync[2]) begin
      // select rising: fresh conversion [RULE_03] [RULE_21]
      nxt_core.state = tsr_pkg::TSR_CONVERT;
      nxt_core.timer = 32'h0;
    end else begin
      case (core_ff.state)
        tsr_pkg::TSR_CONVERT: begin
          nxt_conv_busy = 1'b1;
          if (core_ff.timer >= CONV_CYC - 1) begin
            // two's complement, 0.0625 c per step [RULE_13] [RULE_14]
            nxt_core.result = temp_sample;
            nxt_core.state = tsr_pkg::TSR_WAIT;
          end
          nxt_core.timer = core_ff.timer + 32'h1;
        end
        tsr_pkg::TSR_WAIT: begin
          // continuous conversions at variant period [RULE_01] [RULE_15]
          if (core_ff.timer >= PERIOD_CYC - 1) begin
            nxt_core.state = tsr_pkg::TSR_CONVERT;
            nxt_core.timer = 32'h0;
          end else begin
            nxt_core.timer = core_ff.timer + 32'h1;
          end
        end
        tsr_pkg::TSR_IDLE: begin
          nxt_core.state = tsr_pkg::TSR_CONVERT;
          nxt_core.timer = 32'h0;
        end
        default: nxt_core.state = tsr_pkg::TSR_CONVERT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // zero result, conversion starts after release [RULE_17] [RULE_18]
      core_ff <= '{state: tsr_pkg::TSR_CONVERT, timer: 32'h0,
                   result: `TSR_ZERO_TEMP, done_tgl: 1'b0,
                   sel_sync: 3'h7, sel_seen: 1'b0};
      conv_busy_ff <= 1'b0;
    end else begin
      core_ff <= nxt_core;
      conv_busy_ff <= nxt_conv_busy;
    end
  end

  assign result = core_ff.result;
  assign converting = conv_busy_ff;

  // link domain on sclk; result is stable once select has been low for two clk edges
  tsr_pkg::tsr_link_type link_ff;
  tsr_pkg::tsr_link_type nxt_link;
  logic [15:0] word;

  always_comb begin
    // sign first, confirmation low, two trailing bits floating [RULE_09]
    word = {link_ff.latched, 1'b0, 2'b00};
    nxt_link = link_ff;
    if (link_ff.count < 5'd16) begin
      // shift on falling edge, msb first [RULE_06] [RULE_07] [RULE_16]
      nxt_link.count = link_ff.count + 5'h01;
      if (nxt_link.count < `TSR_BIT_CONFIRM) begin
        nxt_link.so_out = word[4'(5'd16 - nxt_link.count)];
        nxt_link.so_oe = 1'b1;
      end else if (nxt_link.count == `TSR_BIT_CONFIRM) begin
        nxt_link.so_out = 1'b0; // [RULE_10]
        nxt_link.so_oe = 1'b1;
      end else begin
        nxt_link.so_out = 1'b0;
        nxt_link.so_oe = 1'b0; // [RULE_11]
      end
    end
    // beyond sixteenth edge nothing changes [RULE_20]
  end

  // first sclk fall after select falls loads word and drives first bit [RULE_05]
  always_ff @(negedge sclk or posedge sel_n) begin
    if (sel_n) begin
      // select high: interface idle, output floats [RULE_03]
      link_ff <= '{latched: 13'h0000, count: 5'h1F, so_out: 1'b0,
                   so_oe: 1'b0}; // [RULE_12]
    end else if (link_ff.count == 5'h1F) begin
      link_ff <= '{latched: core_ff.result, count: 5'h01,
                   so_out: core_ff.result[12], so_oe: 1'b1};
    end else begin
      link_ff <= nxt_link;
    end
  end

  assign so_out = link_ff.so_out;
  assign so_oe = link_ff.so_oe;
endmodule

/* File: tsr_readout_chk.sv */
// assertions on the readout ports
`timescale 1ns/1ns
module tsr_readout_chk (
  input logic        clk, rst, sel_n, sclk, so_out, so_oe, converting,
  input logic [12:0] result
);
  logic [4:0] falls_ff;
  always_ff @(negedge sclk or posedge sel_n)
    if (sel_n) falls_ff <= 5'h00;
    else if (falls_ff != 5'h1F) falls_ff <= falls_ff + 5'h01;
  rst_val_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> result == 13'h0000) else $error("reset value");
  idle_stop_a: assert property (@(posedge clk) disable iff (rst)
    $fell(sel_n) |-> ##[1:5] !converting) else $error("no idle");
  conv_go_a: assert property (@(posedge clk) disable iff (rst)
    $rose(sel_n) |-> ##[1:5] converting) else $error("no restart");
  res_hold_a: assert property (@(posedge clk) disable iff (rst)
    !sel_n [*5] |=> $stable(result)) else $error("result moved");
  oe_idle_a: assert property (@(posedge clk) disable iff (rst)
    sel_n |-> !so_oe) else $error("driven idle");
  bit_val_a: assert property (@(negedge sclk) disable iff (sel_n)
    falls_ff inside {[1:13]} |-> so_oe && so_out == result[13 - falls_ff])
    else $error("data bit");
  confirm_a: assert property (@(negedge sclk) disable iff (sel_n)
    falls_ff == 14 |-> so_oe && !so_out) else $error("confirm bit");
  tail_hiz_a: assert property (@(negedge sclk) disable iff (sel_n)
    falls_ff > 14 |-> !so_oe) else $error("tail driven");
endmodule
bind tsr_readout tsr_readout_chk u_chk (.*);

/* File: tsr_ctl_model.sv */
// controller model reading the sensor word
`timescale 1ns/1ns
module tsr_ctl_model (input logic so_out, so_oe, output logic sel_n, sclk);
  logic [15:0] word;
  initial begin
    {sel_n, sclk} = 2'h1;
    #1 sel_n = 1'h1;
  end
  task automatic read(input int n);
    sel_n <= 1'h0;
    #493;
    repeat (n) begin
      #100 sclk = 1'h0;
      #100 sclk = 1'h1;
      word = {word[14:0], so_oe ? so_out : 1'hZ};
    end
    #7 sel_n <= 1'h1;
  endtask
endmodule

/* File: testbench.sv */
// bench for the sensor readout
`timescale 1ns/1ns
module testbench;
  logic clk = 1'h0, rst = 1'h1, sel_n, sclk, so_out, so_oe, converting;
  logic [12:0] temp_sample = 13'h0000, result;
  int miscompares = 0, checks_done = 0, cyc = 0;
  tsr_readout #(.CONV_CYC(20), .PERIOD_CYC(40)) u_dut (.*);
  tsr_ctl_model u_ctl (.*);
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) $display("[ERR] %0t %h %h", $time, got, exp);
    miscompares += int'(got !== exp);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 3000) begin
    miscompares++;
    end_of_test();
  end
  task automatic t_word(input logic [12:0] t);
    @(posedge clk);
    temp_sample <= t;
    repeat (100) @(posedge clk);
    chk({3'h0, result}, {3'h0, t});
    u_ctl.read(16);
    chk(u_ctl.word, {t, 1'h0, 2'hZ});
  endtask
  task automatic t_abort();
    repeat (30) @(posedge clk);
    u_ctl.read(5);
    t_word(13'h1FFF);
    repeat (30) @(posedge clk);
    u_ctl.read(20);
    chk({9'h000, u_ctl.word[6:0]}, {9'h000, 1'h0, 6'hZ});
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    t_word(13'h0190);
    t_word(13'h1C90);
    t_abort();
    end_of_test();
  end
endmodule
